// File: core/tofrr_top.sv
// Measurement sequencer and read-only result registers of the interval converter
`timescale 1ns/10ps
`include "tofrr_cfg.svh"
module tofrr_top #(
    parameter int COARSE_DIV   = `TOFRR_COARSE_DIV,
    parameter int CAL2_PERIODS = `TOFRR_CAL2_PERIODS,
    parameter int TIMEOUT_CYC  = `TOFRR_TIMEOUT_NS / `TOFRR_CLK_NS
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic spi_sclk,
    input  wire logic spi_csn,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe,
    output logic      trigger,
    input  wire logic start_pin,
    input  wire logic stop_pin
);
    localparam int          TRIG_CYC = (`TOFRR_TRIG_NS + `TOFRR_CLK_NS - 1) / `TOFRR_CLK_NS;
    localparam logic [15:0] TRIG_LAST = 16'(TRIG_CYC - 1);
    localparam logic [15:0] DIV_LAST  = 16'(COARSE_DIV - 1);
    localparam logic [15:0] CAL1_LAST = 16'(COARSE_DIV - 1);
    localparam logic [15:0] CAL2_LAST = 16'(COARSE_DIV * CAL2_PERIODS - 1);
    localparam logic [22:0] TO_LAST   = 23'(TIMEOUT_CYC - 1);
    localparam int          N         = `TOFRR_NUM_RESULTS;

    tofrr_pkg::tofrr_state_t state_reg;
    tofrr_pkg::tofrr_cmd_t   cmd;
    tofrr_pkg::tofrr_word_t  vis_reg [N];
    logic [22:0]             shadow_reg [N];
    logic [5:0]              rd_addr;
    logic [15:0]             cnt_reg;
    logic [15:0]             div_reg;
    logic [15:0]             coarse_reg;
    logic [22:0]             elapsed_reg;
    logic [2:0]              stops_reg;
    logic                    valid_reg;
    logic [1:0]              edge_reg;
    logic [1:0]              s1_reg;
    logic [1:0]              s2_reg;
    tofrr_pkg::tofrr_word_t  rd_word;

    wire tofrr_pkg::tofrr_pins_t spi_pins =
        '{sclk: spi_sclk, csn: spi_csn, mosi: spi_mosi};

    tofrr_spi u_spi (
        .clock   (clock),
        .rstn    (rstn),
        .ce      (ce),
        .pins    (spi_pins),
        .rd_word (rd_word),
        .rd_addr (rd_addr),
        .cmd     (cmd),
        .miso    (spi_miso),
        .miso_oe (spi_miso_oe)
    );

    // Command decode: only a write to the control register with the start bit set
    wire start_cmd  = cmd.wr && cmd.addr == `TOFRR_ADDR_CTRL
                      && cmd.wdata[`TOFRR_CTRL_START_BIT];
    wire idle       = state_reg == tofrr_pkg::ST_IDLE;
    wire accept     = start_cmd && idle;
    wire start_edge = s2_reg[0] & ~edge_reg[0];
    wire stop_edge  = s2_reg[1] & ~edge_reg[1];
    wire timeout    = elapsed_reg == TO_LAST;
    wire div_wrap   = div_reg == DIV_LAST;
    wire cal_done   = cnt_reg == CAL2_LAST;
    wire cap5       = stop_edge && stops_reg == `TOFRR_STOP5_SEEN;
    wire cap6       = stop_edge && stops_reg == `TOFRR_STOP6_SEEN;
    wire in_count   = state_reg == tofrr_pkg::ST_COUNT;
    wire in_cal     = state_reg == tofrr_pkg::ST_CAL;
    wire in_report  = state_reg == tofrr_pkg::ST_REPORT;
    wire in_results = rd_addr >= `TOFRR_ADDR_STOP5_FINE && rd_addr <= `TOFRR_ADDR_CAL_SECOND;
    wire [2:0] rd_idx = 3'(rd_addr - `TOFRR_ADDR_STOP5_FINE);
    wire tofrr_pkg::tofrr_word_t status_word = {22'h000000, valid_reg, ~idle};
    assign rd_word =
        rd_addr == `TOFRR_ADDR_CTRL ? status_word :
        in_results                  ? vis_reg[rd_idx] : 24'h000000;

    assign trigger = state_reg == tofrr_pkg::ST_TRIG;

    // Front-end pulses come from outside the clock domain
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_reg   <= 2'h0;
            s2_reg   <= 2'h0;
            edge_reg <= 2'h0;
        end else if (ce) begin
            s1_reg   <= {stop_pin, start_pin};
            s2_reg   <= s1_reg;
            edge_reg <= s2_reg;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= tofrr_pkg::ST_IDLE;
            cnt_reg   <= 16'h0000;
            valid_reg <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                tofrr_pkg::ST_IDLE: begin
                    cnt_reg <= 16'h0000;
                    if (accept) begin
                        state_reg <= tofrr_pkg::ST_TRIG;
                        valid_reg <= 1'b0;
                    end
                end
                tofrr_pkg::ST_TRIG: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == TRIG_LAST) begin
                        state_reg <= tofrr_pkg::ST_WAIT_START;
                    end
                end
                tofrr_pkg::ST_WAIT_START: begin
                    cnt_reg <= 16'h0000;
                    if (start_edge) begin
                        state_reg <= tofrr_pkg::ST_COUNT;
                    end else if (timeout) begin
                        state_reg <= tofrr_pkg::ST_CAL;
                    end
                end
                tofrr_pkg::ST_COUNT: begin
                    // Sixth stop or the range limit ends the interval
                    if (cap6 || timeout) begin
                        state_reg <= tofrr_pkg::ST_CAL;
                    end
                end
                tofrr_pkg::ST_CAL: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cal_done) begin
                        state_reg <= tofrr_pkg::ST_REPORT;
                    end
                end
                tofrr_pkg::ST_REPORT: begin
                    state_reg <= tofrr_pkg::ST_IDLE;
                    valid_reg <= 1'b1;
                end
            endcase
        end
    end

    // Elapsed time is shared with the no-start timeout so one counter covers both waits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            elapsed_reg <= 23'h000000;
            div_reg     <= 16'h0000;
            coarse_reg  <= 16'h0000;
            stops_reg   <= 3'h0;
        end else if (ce) begin
            if (idle || (state_reg == tofrr_pkg::ST_WAIT_START && start_edge)) begin
                elapsed_reg <= 23'h000000;
                div_reg     <= 16'h0000;
                coarse_reg  <= 16'h0000;
                stops_reg   <= 3'h0;
            end else if (in_count || state_reg == tofrr_pkg::ST_WAIT_START) begin
                elapsed_reg <= elapsed_reg + 23'h000001;
                div_reg     <= div_wrap ? 16'h0000 : div_reg + 16'h0001;
                coarse_reg  <= coarse_reg + {15'h0000, div_wrap};
                if (in_count && stop_edge && stops_reg != 3'h7) begin
                    stops_reg <= stops_reg + 3'h1;
                end
            end
        end
    end

    // Shadow values: cleared per measurement so an absent stop reports zero
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_res
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    vis_reg[gi] <= '{parity: 1'b0, value: `TOFRR_VALUE_RESET};
                end else if (ce && in_report) begin
                    vis_reg[gi] <= '{parity: ^shadow_reg[gi], value: shadow_reg[gi]};
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                shadow_reg[i] <= `TOFRR_VALUE_RESET;
            end
        end else if (ce) begin
            if (accept) begin
                for (int i = 0; i < N; i++) begin
                    shadow_reg[i] <= `TOFRR_VALUE_RESET;
                end
            end
            if (in_count && cap5) begin
                shadow_reg[0] <= elapsed_reg;
                shadow_reg[1] <= {7'h00, coarse_reg};
            end
            if (in_count && cap6) begin
                shadow_reg[2] <= elapsed_reg;
            end
            if (in_cal && cnt_reg == CAL1_LAST) begin
                shadow_reg[3] <= 23'(cnt_reg) + 23'h000001;
            end
            if (in_cal && cal_done) begin
                shadow_reg[4] <= 23'(cnt_reg) + 23'h000001;
            end
        end
    end

    property p_trig_after_cmd;
        @(posedge clock) disable iff (!rstn) ce && accept |=> trigger;
    endproperty
    a_trig_after_cmd: assert property (p_trig_after_cmd) else $error("No trigger after start");

    property p_trig_width;
        @(posedge clock) disable iff (!rstn) $rose(trigger) |-> trigger [*5];
    endproperty
    a_trig_width: assert property (p_trig_width) else $error("Trigger pulse too short");

    property p_start_runs;
        @(posedge clock) disable iff (!rstn)
            ce && state_reg == tofrr_pkg::ST_WAIT_START && start_edge
            |=> in_count && elapsed_reg == 23'h000000;
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("Start edge did not start counting");

    property p_stop5_capture;
        @(posedge clock) disable iff (!rstn)
            ce && in_count && cap5 |=> shadow_reg[0] == $past(elapsed_reg);
    endproperty
    a_stop5_capture: assert property (p_stop5_capture) else $error("Fifth stop not captured");

    property p_stop6_halts;
        @(posedge clock) disable iff (!rstn) ce && in_count && cap6 |=> in_cal;
    endproperty
    a_stop6_halts: assert property (p_stop6_halts) else $error("Sixth stop did not halt");

    property p_commit_only_report;
        @(posedge clock) disable iff (!rstn)
            !$stable(vis_reg[0]) || !$stable(vis_reg[3]) |-> $past(in_report);
    endproperty
    a_commit_only_report: assert property (p_commit_only_report) else $error("Early commit");

    property p_coarse_upper_zero;
        @(posedge clock) disable iff (!rstn) vis_reg[1].value[22:16] == 7'h00;
    endproperty
    a_coarse_upper_zero: assert property (p_coarse_upper_zero) else $error("Coarse top bits set");

    property p_parity_even;
        @(posedge clock) disable iff (!rstn)
            ^{vis_reg[2].parity, vis_reg[2].value} == 1'b0 && ^vis_reg[4] == 1'b0;
    endproperty
    a_parity_even: assert property (p_parity_even) else $error("Odd parity in result");

    property p_cal_values;
        @(posedge clock) disable iff (!rstn)
            ce && in_report |=> vis_reg[3].value == 23'(COARSE_DIV)
            && vis_reg[4].value == 23'(COARSE_DIV * CAL2_PERIODS);
    endproperty
    a_cal_values: assert property (p_cal_values) else $error("Calibration count wrong");

    property p_clear_on_start;
        @(posedge clock) disable iff (!rstn)
            ce && accept |=> shadow_reg[0] == 23'h000000 && shadow_reg[2] == 23'h000000;
    endproperty
    a_clear_on_start: assert property (p_clear_on_start) else $error("Stale shadow result");
endmodule

// File: core/tofrr_cfg.svh
// Offsets, field positions, reset values and timing figures of the result readout block
`ifndef TOFRR_CFG_SVH
`define TOFRR_CFG_SVH
`define TOFRR_CLK_NS            40
`define TOFRR_ADDR_CTRL         6'h00
`define TOFRR_ADDR_STOP5_FINE   6'h18
`define TOFRR_ADDR_STOP5_COARSE 6'h19
`define TOFRR_ADDR_STOP6_FINE   6'h1a
`define TOFRR_ADDR_CAL_FIRST    6'h1b
`define TOFRR_ADDR_CAL_SECOND   6'h1c
`define TOFRR_NUM_RESULTS       5
`define TOFRR_VALUE_MSB         22
`define TOFRR_COARSE_MSB        15
`define TOFRR_VALUE_RESET       23'h000000
`define TOFRR_CTRL_START_BIT    0
`define TOFRR_STAT_BUSY_BIT     0
`define TOFRR_STAT_VALID_BIT    1
`define TOFRR_CMD_RW_BIT        6
`define TOFRR_CMD_LAST_BIT      5'h07
`define TOFRR_WDATA_LAST_BIT    5'h0f
`define TOFRR_FIRST_DATA_BIT    5'h08
`define TOFRR_STOP5_SEEN        3'h4
`define TOFRR_STOP6_SEEN        3'h5
`define TOFRR_TRIG_NS           200
`define TOFRR_TIMEOUT_NS        8000000
`define TOFRR_COARSE_DIV        8
`define TOFRR_CAL2_PERIODS      10
`endif

// File: core/tofrr_pkg.sv
// Types shared by the result readout block
package tofrr_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_TRIG, ST_WAIT_START, ST_COUNT, ST_CAL, ST_REPORT}
        tofrr_state_t;
    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tofrr_cmd_t;
    typedef struct packed {
        logic        parity;
        logic [22:0] value;
    } tofrr_word_t;
    typedef struct packed {
        logic sclk;
        logic csn;
        logic mosi;
    } tofrr_pins_t;
endpackage

// File: core/tofrr_spi.sv
// Serial slave port: command byte, then 24 read bits or 8 write bits
`timescale 1ns/10ps
`include "tofrr_cfg.svh"
module tofrr_spi (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire tofrr_pkg::tofrr_pins_t pins,
    input  wire tofrr_pkg::tofrr_word_t rd_word,
    output logic [5:0]                 rd_addr,
    output tofrr_pkg::tofrr_cmd_t      cmd,
    output logic                       miso,
    output logic                       miso_oe
);
    tofrr_pkg::tofrr_pins_t s1_reg;
    tofrr_pkg::tofrr_pins_t s2_reg;
    tofrr_pkg::tofrr_cmd_t  cmd_reg;
    logic                   s3_sclk_reg;
    logic [4:0]             bit_reg;
    logic [6:0]             rx_reg;
    logic                   rw_reg;
    logic                   load_reg;
    logic [23:0]            tx_reg;
    logic                   miso_reg;
    logic [5:0]             addr_reg;

    wire       rise    = s2_reg.sclk & ~s3_sclk_reg;
    wire       fall    = ~s2_reg.sclk & s3_sclk_reg;
    wire       active  = ~s2_reg.csn;
    wire [7:0] rx_byte = {rx_reg, s2_reg.mosi};
    wire       shift   = active & fall & (bit_reg >= `TOFRR_FIRST_DATA_BIT);

    // Pins are asynchronous to clock: two stages before any logic looks at them
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_reg      <= '{sclk: 1'b0, csn: 1'b1, mosi: 1'b0};
            s2_reg      <= '{sclk: 1'b0, csn: 1'b1, mosi: 1'b0};
            s3_sclk_reg <= 1'b0;
        end else if (ce) begin
            s1_reg      <= pins;
            s2_reg      <= s1_reg;
            s3_sclk_reg <= s2_reg.sclk;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_reg  <= 5'h00;
            rx_reg   <= 7'h00;
            rw_reg   <= 1'b0;
            load_reg <= 1'b0;
            addr_reg <= 6'h00;
            cmd_reg  <= '0;
        end else if (ce) begin
            cmd_reg.wr <= 1'b0;
            load_reg   <= 1'b0;
            if (!active) begin
                bit_reg <= 5'h00;
            end else if (rise) begin
                rx_reg <= rx_byte[6:0];
                if (bit_reg != 5'h1f) begin
                    bit_reg <= bit_reg + 5'h01;
                end
                if (bit_reg == `TOFRR_CMD_LAST_BIT) begin
                    addr_reg <= rx_byte[5:0];
                    rw_reg   <= rx_byte[`TOFRR_CMD_RW_BIT];
                    load_reg <= 1'b1;
                end
                if (bit_reg == `TOFRR_WDATA_LAST_BIT && rw_reg) begin
                    cmd_reg <= '{wr: 1'b1, addr: addr_reg, wdata: rx_byte};
                end
            end
        end
    end

    // Read word is frozen at the command byte so a result commit mid-frame cannot tear it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_reg   <= 24'h000000;
            miso_reg <= 1'b0;
        end else if (ce) begin
            if (load_reg) begin
                tx_reg <= rd_word;
            end else if (shift) begin
                miso_reg <= tx_reg[23];
                tx_reg   <= {tx_reg[22:0], 1'b0};
            end else if (!active) begin
                miso_reg <= 1'b0;
            end
        end
    end

    assign rd_addr = addr_reg;
    assign cmd     = cmd_reg;
    assign miso    = miso_reg;
    assign miso_oe = active;
endmodule

// File: tb/tofrr_host.sv
// Host side model: serial master framing one command per chip-select period
`timescale 1ns/10ps
module tofrr_host (
    input  wire logic clock,
    output logic      spi_sclk,
    output logic      spi_csn,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // Six clocks a phase keeps sclk inside what the pin synchronisers can follow
    localparam int HALF = 6;
    initial begin
        spi_sclk = 1'b0;
        spi_csn  = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wdata, output logic [23:0] rd);
        int          nbits;
        logic [15:0] sh;
        nbits = cmd[6] ? 16 : 32;
        sh = {cmd, wdata};
        rd = 24'h000000;
        @(posedge clock);
        spi_csn  <= 1'b0;
        spi_mosi <= sh[15];
        for (int i = 0; i < nbits; i++) begin
            repeat (HALF - 1) @(posedge clock);
            @(negedge clock);
            if (i >= 8) rd = {rd[22:0], spi_miso};
            @(posedge clock);
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge clock);
            spi_sclk <= 1'b0;
            spi_mosi <= (i < 15) ? sh[14 - i] : ~spi_mosi;
        end
        repeat (HALF) @(posedge clock);
        spi_csn  <= 1'b1;
        // Released line shows the inverse, never a stale level
        spi_mosi <= ~spi_mosi;
        repeat (HALF) @(posedge clock);
    endtask
    task automatic start_cmd();
        logic [23:0] unused;
        frame(8'h40, 8'h01, unused);
    endtask
endmodule

// File: tb/tof_result_register_readout_test.sv
// Self-checking bench for the measurement sequencer and result registers
`timescale 1ns/10ps
module tof_result_register_readout_test;
    localparam int CDIV  = 8;
    localparam int CAL2  = 20;
    localparam int TMO   = 2000;
    localparam int LIMIT = 30000;
    typedef struct packed {
        logic [5:0]  addr;
        logic [23:0] exp;
    } tofrr_row_t;
    logic        clock     = 1'b0;
    logic        rstn      = 1'b0;
    logic        ce        = 1'b1;
    logic        start_pin = 1'b0;
    logic        stop_pin  = 1'b0;
    logic        spi_sclk;
    logic        spi_csn;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic        trigger;
    logic [23:0] rd;
    logic [23:0] fine5;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    int          trig_count   = 0;
    int          now          = 0;
    int          offs [6]     = '{20, 40, 60, 80, 164, 201};
    tofrr_row_t  rows [7]     = '{'{6'h18, 24'h0}, '{6'h19, 24'h0}, '{6'h1a, 24'h0},
        '{6'h1b, 24'h0}, '{6'h1c, 24'h0}, '{6'h00, 24'h0}, '{6'h3f, 24'h0}};

    tofrr_top #(.COARSE_DIV(CDIV), .CAL2_PERIODS(CAL2), .TIMEOUT_CYC(TMO)) i_dut (
        .clock       (clock),
        .rstn        (rstn),
        .ce          (ce),
        .spi_sclk    (spi_sclk),
        .spi_csn     (spi_csn),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .trigger     (trigger),
        .start_pin   (start_pin),
        .stop_pin    (stop_pin)
    );
    tofrr_host i_host (
        .clock    (clock),
        .spi_sclk (spi_sclk),
        .spi_csn  (spi_csn),
        .spi_mosi (spi_mosi),
        .spi_miso (spi_miso)
    );

    always #20 clock = ~clock;
    always @(negedge clock) begin
        if (trigger === 1'b1) trig_count++;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("[FAIL] run length expected below %0d seen %0d", LIMIT, cycles);
            stop_test();
        end
    end

    function automatic logic [23:0] mk_word(input logic [22:0] v);
        return {^v, v};
    endfunction
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
        i_host.frame({2'b00, a}, 8'h00, d);
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] wd);
        logic [23:0] unused;
        i_host.frame({2'b01, a}, wd, unused);
    endtask
    task automatic pulse_start();
        @(posedge clock);
        start_pin <= 1'b1;
        repeat (3) @(posedge clock);
        start_pin <= 1'b0;
        now = 3;
    endtask
    // Stop edge lands exactly at clocks after the start edge, so gaps are exact
    task automatic pulse_stop(input int at);
        repeat (at - now) @(posedge clock);
        stop_pin <= 1'b1;
        repeat (3) @(posedge clock);
        stop_pin <= 1'b0;
        now = at + 3;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        check("miso enable idle", 24'h0, {23'h0, spi_miso_oe});
        foreach (rows[i]) begin
            rd_reg(rows[i].addr, rd);
            check("reset read", rows[i].exp, rd);
        end
        wr_reg(6'h18, 8'hff);
        rd_reg(6'h18, rd);
        check("result after write", 24'h0, rd);
        wr_reg(6'h00, 8'h00);
        check("trigger clocks no start", 24'd0, 24'(trig_count));
        i_host.start_cmd();
        check("trigger clocks", 24'd5, 24'(trig_count));
        i_host.start_cmd();
        check("trigger clocks while busy", 24'd5, 24'(trig_count));
        rd_reg(6'h00, rd);
        check("status waiting", 24'h000001, rd);
        pulse_start();
        foreach (offs[i]) pulse_stop(offs[i]);
        // Snapshot is taken while calibration still runs
        rd_reg(6'h00, rd);
        check("status calibrating", 24'h000001, rd);
        rd_reg(6'h18, fine5);
        check("stop5 fine in range", 24'h1,
            {23'h0, fine5[22:0] >= 23'd163 && fine5[22:0] <= 23'd165});
        check("stop5 fine parity", mk_word(fine5[22:0]), fine5);
        rd_reg(6'h19, rd);
        check("stop5 coarse", mk_word(23'd20), rd);
        rd_reg(6'h1a, rd);
        check("stop6 gap", 24'd37, {1'b0, rd[22:0] - fine5[22:0]});
        check("stop6 parity", mk_word(rd[22:0]), rd);
        rd_reg(6'h1b, rd);
        check("first cal", mk_word(23'(CDIV)), rd);
        rd_reg(6'h1c, rd);
        check("second cal", mk_word(23'(CDIV * CAL2)), rd);
        rd_reg(6'h00, rd);
        check("status done", 24'h000002, rd);
        i_host.start_cmd();
        check("trigger clocks again", 24'd10, 24'(trig_count));
        pulse_start();
        for (int i = 0; i < 3; i++) pulse_stop(offs[i]);
        repeat (TMO + CDIV * CAL2 + 50) @(posedge clock);
        rd_reg(6'h18, rd);
        check("missing stop5 fine", 24'h0, rd);
        rd_reg(6'h19, rd);
        check("missing stop5 coarse", 24'h0, rd);
        rd_reg(6'h1a, rd);
        check("missing stop6 fine", 24'h0, rd);
        rd_reg(6'h1b, rd);
        check("first cal again", mk_word(23'(CDIV)), rd);
        rd_reg(6'h00, rd);
        check("status done again", 24'h000002, rd);
        // Frozen enable holds the sequencer, so the no-start timeout, begun in the last clocks of the start frame, ends only after it returns
        i_host.start_cmd();
        check("trigger clocks third", 24'd15, 24'(trig_count));
        ce <= 1'b0;
        repeat (TMO + CDIV * CAL2 + 50) @(posedge clock);
        ce <= 1'b1;
        rd_reg(6'h00, rd);
        check("status while frozen", 24'h000001, rd);
        repeat (TMO + CDIV * CAL2 + 50) @(posedge clock);
        rd_reg(6'h00, rd);
        check("status after no start", 24'h000002, rd);
        rd_reg(6'h1a, rd);
        check("no start stop6 fine", 24'h0, rd);
        rd_reg(6'h1c, rd);
        check("second cal again", mk_word(23'(CDIV * CAL2)), rd);
        stop_test();
    end
endmodule
